// ---- elfs_event_log.sv ----
// Event log status and buffer index control: register slave, channel priority, flags.
// Assumes a single synchronous clock, synchronous channel levels and a plain
// strobe register port with read data one cycle after the read strobe.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`include "elfs_params.svh"

////////////////////////////////////////////////////////////////////////////////
// Function
// - Pulse sequencer start when unread flag rises
// - Separate full, threshold, unread interrupt outputs
// - Logger status output for a pin
// - Unread flag offered as processor start
// - Clear bit empties buffer; bit 0 enables
// - Timer select field, code 00 timer one
// - Threshold flag when free space <= field
// - Full flag set when full, cleared by index change
// - Unread flag when any entry unread
// - Read-only write index in bits 11:8
// - Writable read index in bits 3:0
// - Sixteen channel enable bits, reset zero
// - Sixteen read-only channel level bits
// - One event per cycle, lowest channel first
// - Cyclic fill, never overwrite unread entries
// - Logger clear zeroes both indexes
module elfs_event_log #(
	parameter int CHANNELS = 16,
	parameter int DEPTH    = 16
) (
	input  wire logic                    clock_i,
	input  wire logic                    rst_b_i,
	input  wire logic [`ELFS_ADDR_W-1:0] addr_i,
	input  wire logic [31:0]             wdata_i,
	input  wire logic                    wr_i,
	input  wire logic                    rd_i,
	output logic      [31:0]             rdata_o,
	input  wire logic [CHANNELS-1:0]     channel_level_i,
	output logic                         log_valid_o,
	output logic      [3:0]              log_channel_o,
	output logic      [3:0]              log_slot_o,
	output logic      [1:0]              timestamp_timer_choice_o,
	output logic                         irq_full_o,
	output logic                         irq_threshold_o,
	output logic                         irq_not_empty_o,
	output logic                         gpio_status_o,
	output logic                         seq_start_o,
	output logic                         dsp_start_o
);

	// Indexes and the channel mask are hard four and sixteen bits wide
	if (CHANNELS != 16 || DEPTH != 16) begin : g_size_check
		$error("elfs_event_log serves only 16 channels and 16 entries");
	end

	////////////////////////////////////////////////////////////////////////////
	// State

	elfs_pkg::elfs_state_s st;
	elfs_pkg::elfs_state_s next_st;

	logic [15:0] level;
	logic [15:0] rise;
	logic [15:0] req;
	logic [3:0]  unread;
	logic [4:0]  used;
	logic [4:0]  free;
	logic        is_full;
	logic        is_empty;
	logic [3:0]  pick;
	logic        have_pick;
	logic [31:0] rd_val;
	logic        clear_now;

	assign level = channel_level_i;

	// Priority encoder, lowest channel wins
	always_comb begin
		pick      = 4'h0;
		have_pick = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			if (req[i]) begin
				pick      = 4'(i);
				have_pick = 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		next_st   = st;
		clear_now = wr_i && (addr_i == `ELFS_OFF_CONTROL) && wdata_i[`ELFS_BIT_CLEAR];

		unread   = st.write_idx - st.read_idx;
		is_full  = (unread == 4'h0) && st.buffer_full_flag;
		is_empty = (unread == 4'h0) && !st.buffer_full_flag;
		used     = is_full ? 5'h10 : {1'b0, unread};
		free     = 5'h10 - used;

		// Edge since last cycle; a level already high when the logger is enabled is not logged
		rise = level & ~st.prev_level & st.channel_on_bit;
		req  = st.pending | rise;

		next_st.prev_level = st.logger_on ? level : 16'h0000;
		next_st.log_valid  = 1'b0;
		next_st.mode       = st.logger_on ? elfs_pkg::ELFS_ACTIVE : elfs_pkg::ELFS_IDLE;

		case (st.mode)
			elfs_pkg::ELFS_ACTIVE: begin
				// Full buffer drops events, queued ones included
				if (is_full) begin
					next_st.pending = 16'h0000;
				end else if (have_pick) begin
					next_st.pending          = req & ~(16'h0001 << pick);
					next_st.log_valid        = 1'b1;
					next_st.log_channel      = pick;
					next_st.log_slot         = st.write_idx;
					next_st.write_idx        = st.write_idx + 4'h1;
					if (unread == 4'hF) begin
						next_st.buffer_full_flag = 1'b1;
					end
				end else begin
					next_st.pending = req;
				end
			end
			elfs_pkg::ELFS_IDLE: begin
				next_st.pending = 16'h0000;
			end
			default: begin
				next_st.pending = 16'h0000;
			end
		endcase

		// Register writes
		if (wr_i) begin
			case (addr_i)
				`ELFS_OFF_CONTROL: begin
					next_st.logger_on = wdata_i[`ELFS_BIT_ON];
				end
				`ELFS_OFF_TIMER_SEL: begin
					next_st.timestamp_timer_choice = wdata_i[1:0];
				end
				`ELFS_OFF_THRESH: begin
					next_st.free_space_threshold = wdata_i[3:0];
				end
				`ELFS_OFF_INDEX: begin
					// Same value keeps the full flag: a real change is needed
					if (wdata_i[3:0] != st.read_idx) begin
						next_st.buffer_full_flag = 1'b0;
					end
					next_st.read_idx = wdata_i[3:0];
				end
				`ELFS_OFF_CH_ENABLE: begin
					next_st.channel_on_bit = wdata_i[15:0];
				end
				default: begin
				end
			endcase
		end

		// Logger clear beats any logging this cycle
		if (clear_now) begin
			next_st.write_idx        = 4'h0;
			next_st.read_idx         = 4'h0;
			next_st.buffer_full_flag = 1'b0;
			next_st.pending          = 16'h0000;
			next_st.log_valid        = 1'b0;
			next_st.prev_not_empty   = 1'b0;
		end

		// Flags from the state being registered
		begin
			unread = next_st.write_idx - next_st.read_idx;
			is_full = (unread == 4'h0) && next_st.buffer_full_flag;
			used = is_full ? 5'h10 : {1'b0, unread};
			free = 5'h10 - used;
			next_st.flags.full      = next_st.buffer_full_flag;
			next_st.flags.not_empty = is_full || (unread != 4'h0);
			next_st.flags.thresh    = free <= {1'b0, next_st.free_space_threshold};
			if (clear_now) begin
				next_st.flags = '0;
			end
		end
		next_st.seq_start      = next_st.flags.not_empty && !st.flags.not_empty;
		next_st.prev_not_empty = st.flags.not_empty;

		// Read data
		rd_val = 32'h0000_0000;
		case (addr_i)
			`ELFS_OFF_CONTROL:   rd_val = {31'h0, st.logger_on};
			`ELFS_OFF_TIMER_SEL: rd_val = {30'h0, st.timestamp_timer_choice};
			`ELFS_OFF_THRESH:    rd_val = {28'h0, st.free_space_threshold};
			`ELFS_OFF_INDEX:     rd_val = {13'h0, st.flags.full, st.flags.thresh,
				st.flags.not_empty, 4'h0, st.write_idx, 4'h0, st.read_idx};
			`ELFS_OFF_CH_ENABLE: rd_val = {16'h0, st.channel_on_bit};
			`ELFS_OFF_CH_LEVEL:  rd_val = {16'h0, level};
			default:             rd_val = 32'h0000_0000;
		endcase
		next_st.rdata = rd_i ? rd_val : 32'h0000_0000;
	end

	////////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			st                      <= '0;
			st.mode                 <= elfs_pkg::ELFS_IDLE;
			st.free_space_threshold <= `ELFS_RST_THRESH;
			st.timestamp_timer_choice <= `ELFS_TIMER_ONE;
		end else begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign rdata_o                  = st.rdata;
	assign log_valid_o              = st.log_valid;
	assign log_channel_o            = st.log_channel;
	assign log_slot_o               = st.log_slot;
	assign timestamp_timer_choice_o = st.timestamp_timer_choice;
	assign irq_full_o               = st.flags.full;
	assign irq_threshold_o          = st.flags.thresh;
	assign irq_not_empty_o          = st.flags.not_empty;
	assign gpio_status_o            = st.flags.not_empty;
	assign seq_start_o              = st.seq_start;
	assign dsp_start_o              = st.flags.not_empty;

endmodule : elfs_event_log

// ---- elfs_params.svh ----
// Register offsets, field positions, reset values for the event log status block.
// Included by the package and the design; definitions only.
`ifndef ELFS_PARAMS_SVH
`define ELFS_PARAMS_SVH

`define ELFS_ADDR_W          20
`define ELFS_OFF_CONTROL     20'h48000
`define ELFS_OFF_TIMER_SEL   20'h48004
`define ELFS_OFF_THRESH      20'h4800C
`define ELFS_OFF_INDEX       20'h4800E
`define ELFS_OFF_CH_ENABLE   20'h48020
`define ELFS_OFF_CH_LEVEL    20'h48024

`define ELFS_BIT_ON          0
`define ELFS_BIT_CLEAR       1
`define ELFS_BIT_NOT_EMPTY   16
`define ELFS_BIT_THRESH      17
`define ELFS_BIT_FULL        18
`define ELFS_WIDX_LSB        8

`define ELFS_RST_THRESH      4'h1
`define ELFS_TIMER_ONE       2'h0

`endif

// ---- elfs_pkg.sv ----
// Types shared by the event log status block.
// Assumes elfs_params.svh is on the include path.
`include "elfs_params.svh"

package elfs_pkg;

	typedef enum logic [1:0] {
		ELFS_IDLE   = 2'h0,
		ELFS_ACTIVE = 2'h1
	} elfs_mode_e;

	typedef struct packed {
		logic full;
		logic thresh;
		logic not_empty;
	} elfs_flags_s;

	typedef struct packed {
		elfs_mode_e     mode;
		logic           logger_on;
		logic [1:0]     timestamp_timer_choice;
		logic [3:0]     free_space_threshold;
		logic [3:0]     write_idx;
		logic [3:0]     read_idx;
		logic           buffer_full_flag;
		logic [15:0]    channel_on_bit;
		logic [15:0]    pending;
		logic [15:0]    prev_level;
		logic           prev_not_empty;
		logic           seq_start;
		logic           log_valid;
		logic [3:0]     log_channel;
		logic [3:0]     log_slot;
		logic [31:0]    rdata;
		elfs_flags_s    flags;
	} elfs_state_s;

endpackage : elfs_pkg

// ---- elfs_event_log_monitor.sv ----
// Concurrent checks on the event log status block ports.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`include "elfs_params.svh"
module elfs_event_log_monitor (
	input wire logic                    clock_i,
	input wire logic                    rst_b_i,
	input wire logic [`ELFS_ADDR_W-1:0] addr_i,
	input wire logic                    wr_i,
	input wire logic                    rd_i,
	input wire logic [31:0]             rdata_o,
	input wire logic                    log_valid_o,
	input wire logic [3:0]              log_slot_o,
	input wire logic                    irq_full_o,
	input wire logic                    irq_not_empty_o,
	input wire logic                    gpio_status_o,
	input wire logic                    seq_start_o,
	input wire logic                    dsp_start_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_b_i);
	////////////////////////////////////////
	chk_seq_on_rise: assert property (seq_start_o == $rose(irq_not_empty_o))
		else $error("sequencer start not tied to unread rise");
	chk_gpio_level: assert property (gpio_status_o == irq_not_empty_o)
		else $error("pin status differs from unread flag");
	chk_dsp_level: assert property (dsp_start_o == irq_not_empty_o)
		else $error("processor start differs from unread flag");
	chk_clear_reads_zero: assert property ($past(rd_i) && $past(addr_i) == `ELFS_OFF_CONTROL |-> !rdata_o[1])
		else $error("clear bit read back as one");
	chk_full_no_log: assert property (log_valid_o |-> !$past(irq_full_o))
		else $error("event logged while full");
	chk_full_clear: assert property ($fell(irq_full_o) |-> $past(wr_i) && ($past(addr_i) == `ELFS_OFF_INDEX || $past(addr_i) == `ELFS_OFF_CONTROL))
		else $error("full flag dropped without index write or clear");
	// A read index write can also open unread entries
	chk_seq_by_log: assert property (seq_start_o |-> log_valid_o || ($past(wr_i) && $past(addr_i) == `ELFS_OFF_INDEX))
		else $error("unread rose without a logged event or index write");
	chk_log_unread: assert property (log_valid_o |-> irq_not_empty_o)
		else $error("logged event left buffer empty");
	chk_slot_step: assert property (log_valid_o && $past(log_valid_o) && !$past(wr_i) |-> log_slot_o == $past(log_slot_o) + 4'h1)
		else $error("write slot did not advance by one");
	cover property (log_valid_o && $past(log_valid_o));
	cover property (irq_full_o);
	cover property ($fell(irq_full_o));
endmodule : elfs_event_log_monitor
bind elfs_event_log elfs_event_log_monitor elfs_event_log_monitor_i (.*);

// ---- elfs_host_model.sv ----
// Host software model: strobe register accesses on the plain port.
// Assumes read data stands only in the cycle after the read strobe.
`timescale 1ns/1ps
`include "elfs_params.svh"
module elfs_host_model (
	input  wire logic                    clock_i,
	input  wire logic [31:0]             rdata_i,
	output logic      [`ELFS_ADDR_W-1:0] addr_o,
	output logic      [31:0]             wdata_o,
	output logic                         wr_o,
	output logic                         rd_o
);
	initial begin
		addr_o = '0;
		wdata_o = '0;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end
	////////////////////////////////////////
	task automatic wr(input logic [`ELFS_ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge clock_i);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge clock_i);
		wr_o <= 1'b0;
	endtask : wr
	// Data sampled once settled, in the only cycle it stands
	task automatic rd(input logic [`ELFS_ADDR_W-1:0] a, output logic [31:0] d);
		@(posedge clock_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge clock_i);
		rd_o <= 1'b0;
		#1 d = rdata_i;
	endtask : rd
endmodule : elfs_host_model

// ---- elfs_event_log_tb_top.sv ----
// Self-checking bench for the event log status block.
// Assumes the host model drives the register port.
`timescale 1ns/1ps
`include "elfs_params.svh"
module elfs_event_log_tb_top;
	logic                    clock_i, rst_b_i, wr, rd, lv, ifl, ith, ine, gp, sq, ds;
	logic [`ELFS_ADDR_W-1:0] addr;
	logic [31:0]             wdata, rdata, v;
	logic [15:0]             lvl;
	logic [3:0]              lch, lsl;
	logic [1:0]              tsel;
	int                      fail_count = 0, compares = 0, logs = 0;
	logic [19:0] ra [7] = '{`ELFS_OFF_TIMER_SEL, `ELFS_OFF_THRESH, `ELFS_OFF_CH_ENABLE,
		`ELFS_OFF_CH_LEVEL, `ELFS_OFF_INDEX, 20'h40000, `ELFS_OFF_CONTROL};
	logic [31:0] rr [7] = '{32'h0, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
	logic [31:0] rw [7] = '{32'h0, 32'hF, 32'hFFFF8001, 32'hFFFF, 32'hF05, 32'hFFFFFFFF, 32'h3};
	logic [31:0] re [7] = '{32'h0, 32'hF, 32'h8001, 32'h0, 32'h30005, 32'h0, 32'h1};
	elfs_host_model elfs_host_model_i (.clock_i(clock_i), .rdata_i(rdata), .addr_o(addr),
		.wdata_o(wdata), .wr_o(wr), .rd_o(rd));
	elfs_event_log elfs_event_log_i (.clock_i(clock_i), .rst_b_i(rst_b_i), .addr_i(addr),
		.wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .channel_level_i(lvl),
		.log_valid_o(lv), .log_channel_o(lch), .log_slot_o(lsl),
		.timestamp_timer_choice_o(tsel), .irq_full_o(ifl), .irq_threshold_o(ith),
		.irq_not_empty_o(ine), .gpio_status_o(gp), .seq_start_o(sq), .dsp_start_o(ds));
	////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
			fail_count++;
		end
	endtask : check
	task automatic final_report();
		if (fail_count == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : final_report
	task automatic idx(input logic [31:0] exp);
		elfs_host_model_i.rd(`ELFS_OFF_INDEX, v);
		check(v, exp);
	endtask : idx
	////////////////////////////////////////
	initial begin
		clock_i = 1'b0;
		forever #4 clock_i = ~clock_i;
	end
	always @(posedge clock_i) if (lv === 1'b1) logs <= logs + 1;
	// Hang guard
	initial begin
		#200000;
		fail_count++;
		final_report();
	end
	initial begin
		lvl = 16'h0;
		rst_b_i = 1'b0;
		repeat (16) @(posedge clock_i);
		rst_b_i <= 1'b1;
		for (int i = 0; i < 7; i++) begin
			elfs_host_model_i.rd(ra[i], v);
			check(v, rr[i]);
		end
		// Timer field written while the logger is still off
		for (int i = 0; i < 7; i++) begin
			elfs_host_model_i.wr(ra[i], rw[i]);
			elfs_host_model_i.rd(ra[i], v);
			check(v, re[i]);
		end
		idx(32'h0);
		check({30'h0, tsel}, 32'h0);
		@(posedge clock_i);
		lvl <= 16'h8001;
		@(posedge clock_i);
		#1 check({lch, lsl, 23'h0, lv}, 32'h00000001);
		@(posedge clock_i);
		#1 check({lch, lsl, 23'h0, lv}, 32'hF1000001);
		check({29'h0, ifl, ith, ine}, 32'h3);
		check({29'h0, gp, ds, sq}, 32'h6);
		// Fourteen more rises fill the buffer, one more is dropped
		repeat (15) begin
			@(posedge clock_i);
			lvl[0] <= 1'b0;
			@(posedge clock_i);
			lvl[0] <= 1'b1;
		end
		repeat (2) @(posedge clock_i);
		check(logs, 32'h10);
		idx(32'h70000);
		elfs_host_model_i.wr(`ELFS_OFF_INDEX, 32'h0);
		idx(32'h70000);
		elfs_host_model_i.wr(`ELFS_OFF_INDEX, 32'h4);
		idx(32'h30004);
		elfs_host_model_i.rd(`ELFS_OFF_CH_LEVEL, v);
		check(v, 32'h8001);
		// Reset in mid-run must bring indexes, flags and threshold back
		rst_b_i <= 1'b0;
		repeat (2) @(posedge clock_i);
		rst_b_i <= 1'b1;
		idx(32'h0);
		elfs_host_model_i.rd(`ELFS_OFF_THRESH, v);
		check(v, 32'h1);
		final_report();
	end
endmodule : elfs_event_log_tb_top
